// >>> hw/pqs_sequencer.sv
// What this block does
// - psk symbols advance once per baud period
// - psk baud leaves two-phase keying untouched
// - psk carrier enable defaults on, readable
// - user psk phase from table, 9 bits, 0..511
// - user phase entries stored at auto indices
// - qam type picks 16/64/256 word widths
// - two leading bits decode the quadrant
// - remaining bits give in-quadrant position
// - qam table stepped in order per baud
// - user qam symbols from user table
// - qam type resets to 16-point
// - qam carrier enable defaults on, readable
// - qam bit string grouped into words
// - sync pulse at programmed marker index
// - bpsk 0 start phase, finish cycle
`include "pqs_cfg.svh"
module pqs_sequencer
  import pqs_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      run,
  input  wire logic                      psk_sel,
  input  wire logic [2:0]                psk_type,
  input  wire logic [1:0]                qam_type,
  input  wire logic                      qam_type_wr,
  input  wire logic [31:0]               bpsk_baud,
  input  wire logic [31:0]               psk_baud,
  input  wire logic                      psk_baud_wr,
  input  wire logic [31:0]               qam_baud,
  input  wire logic                      qam_baud_wr,
  input  wire logic                      psk_carr_val,
  input  wire logic                      psk_carr_wr,
  input  wire logic                      qam_carr_val,
  input  wire logic                      qam_carr_wr,
  input  wire logic [`PQS_IDX_W-1:0]     mark_val,
  input  wire logic                      mark_wr,
  input  wire logic                      data_clear,
  input  wire logic                      data_bit,
  input  wire logic                      data_bit_wr,
  input  wire logic                      sym_clear,
  input  wire logic [15:0]               sym_val,
  input  wire logic                      sym_wr,
  input  wire logic                      cycle_end,
  output logic      [1:0]                qam_type_rd,
  output logic      [31:0]               psk_baud_rd,
  output logic      [31:0]               qam_baud_rd,
  output logic                           psk_carr_rd,
  output logic                           qam_carr_rd,
  output logic      [`PQS_IDX_W-1:0]     mark_rd,
  output logic      [`PQS_IDX_W:0]       data_len_rd,
  output logic                           busy,
  output logic                           out_valid,
  input  wire logic                      out_ready,
  output logic      [23:0]               out_data,
  output logic                           sync_out
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    pqs_state_t                st;
    logic [1:0]                qtype;
    logic [31:0]               pbaud;
    logic [31:0]               qbaud;
    logic                      pcarr;
    logic                      qcarr;
    logic [`PQS_IDX_W-1:0]     mark;
    logic [`PQS_IDX_W:0]       wlen;
    logic [3:0]                wfill;
    logic [7:0]                wacc;
    logic [`PQS_IDX_W-1:0]     blen;
    logic [7:0]                slen;
    logic [`PQS_IDX_W-1:0]     idx;
    logic [`PQS_ACC_W-1:0]     acc;
    logic                      sync;
  } pqs_st_t;

  pqs_st_t                 s_q;
  pqs_st_t                 s_d;
  logic [7:0]              word_mem [`PQS_TBL_DEPTH];
  logic [15:0]             sym_mem  [`PQS_SYM_TBL_DEPTH];
  pqs_mode_t               mode;
  logic [3:0]              wbits;
  logic [31:0]             baud;
  logic [`PQS_ACC_W:0]     acc_sum;
  logic                    tick;
  logic                    f_ready;
  logic                    w_done;
  logic [7:0]              cur_word;
  logic [23:0]             sym;

  // -----------------------------------------------------------------
  // mode and word width
  // -----------------------------------------------------------------
  always_comb begin
    if (!psk_sel) mode = pqs_mode_t'(3'h3 + {1'b0, s_q.qtype});
    else if (psk_type == 3'h0) mode = PQS_BPSK;
    else if (psk_type == 3'h7) mode = PQS_UPSK;
    else mode = PQS_NPSK;
    unique case (mode)
      PQS_BPSK:   wbits = 4'h1;
      PQS_NPSK:   wbits = {1'b0, psk_type};
      PQS_UPSK:   wbits = 4'h8;
      PQS_QAM16:  wbits = 4'h4;
      PQS_QAM64:  wbits = 4'h6;
      PQS_QAM256: wbits = 4'h8;
      default:    wbits = 4'h8;
    endcase
    // two-phase keying ignores the multi-level baud
    if (mode == PQS_BPSK) baud = bpsk_baud;
    else if (psk_sel) baud = s_q.pbaud;
    else baud = s_q.qbaud;
  end

  // -----------------------------------------------------------------
  // baud generator: phase accumulator on the 10 MHz clock
  // -----------------------------------------------------------------
  assign acc_sum = {1'b0, s_q.acc} + {1'b0, baud};
  assign tick    = (acc_sum >= {1'b0, `PQS_CLK_HZ});
  assign w_done  = data_bit_wr && ({s_q.wfill + 4'h1} == wbits);
  assign cur_word = word_mem[s_q.idx];

  // -----------------------------------------------------------------
  // symbol mapping
  // -----------------------------------------------------------------
  always_comb begin
    sym = 24'h000000;
    unique case (mode)
      PQS_BPSK: sym = {4'h0, mode, 1'b0, 7'h00, cur_word[0], 8'h00};
      PQS_NPSK: sym = {4'h0, mode, 1'b0, 8'h00, cur_word};
      PQS_UPSK: sym = {4'h0, mode, 1'b0, 7'h00, sym_mem[cur_word][`PQS_PHASE_W-1:0]};
      PQS_QAM16: sym = {4'h0, mode, 1'b0, 6'h00, cur_word[3:2], 6'h00, cur_word[1:0]};
      PQS_QAM64: sym = {4'h0, mode, 1'b0, 6'h00, cur_word[5:4], 4'h0, cur_word[3:0]};
      PQS_QAM256: sym = {4'h0, mode, 1'b0, 6'h00, cur_word[7:6], 2'h0, cur_word[5:0]};
      default: sym = {4'h0, mode, 1'b0, sym_mem[cur_word]};
    endcase
    if (mode == PQS_BPSK) sym[23] = 1'b1;
    else sym[23] = psk_sel ? s_q.pcarr : s_q.qcarr;
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.sync = 1'b0;
    if (psk_baud_wr && psk_baud != 32'h0 && psk_baud <= `PQS_BAUD_MAX_HZ) s_d.pbaud = psk_baud;
    if (qam_baud_wr && qam_baud != 32'h0 && qam_baud <= `PQS_BAUD_MAX_HZ) s_d.qbaud = qam_baud;
    if (psk_carr_wr) s_d.pcarr = psk_carr_val;
    if (qam_carr_wr) s_d.qcarr = qam_carr_val;
    if (qam_type_wr) s_d.qtype = qam_type;
    if (mark_wr && mark_val >= `PQS_MARK_MIN && mark_val <= `PQS_MARK_MAX) s_d.mark = mark_val;
    if (sym_clear) s_d.slen = 8'h00;
    else if (sym_wr) s_d.slen = s_q.slen + 8'h01;
    if (data_clear) begin
      s_d.wlen  = '0;
      s_d.wfill = 4'h0;
      s_d.wacc  = 8'h00;
    end else if (data_bit_wr && s_q.st != PQS_RUN) begin
      s_d.wacc  = {s_q.wacc[6:0], data_bit};
      s_d.wfill = w_done ? 4'h0 : s_q.wfill + 4'h1;
      if (w_done && s_q.wlen != (`PQS_IDX_W+1)'(`PQS_TBL_DEPTH)) s_d.wlen = s_q.wlen + 1'b1;
    end
    unique case (s_q.st)
      PQS_IDLE: begin
        s_d.acc = '0;
        s_d.idx = '0;
        if (run && s_q.wlen != '0) s_d.st = PQS_RUN;
      end
      PQS_RUN: begin
        if (f_ready) begin
          s_d.acc = tick ? `PQS_ACC_W'(acc_sum - {1'b0, `PQS_CLK_HZ}) : acc_sum[`PQS_ACC_W-1:0];
          if (tick) begin
            s_d.sync = ({1'b0, s_q.idx} + 13'h1 == {1'b0, s_q.mark});
            if ({1'b0, s_q.idx} + 13'h1 >= s_q.wlen) s_d.idx = '0;
            else s_d.idx = s_q.idx + 1'b1;
            if (!run) s_d.st = PQS_STOP;
          end
        end
      end
      PQS_STOP: begin
        if (cycle_end) s_d.st = PQS_IDLE;
      end
      default: s_d.st = PQS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q       <= '0;
      s_q.st    <= PQS_IDLE;
      s_q.qtype <= 2'h0;
      s_q.pbaud <= `PQS_BAUD_DEF_HZ;
      s_q.qbaud <= `PQS_BAUD_DEF_HZ;
      s_q.pcarr <= `PQS_CARR_DEF;
      s_q.qcarr <= `PQS_CARR_DEF;
      s_q.mark  <= `PQS_MARK_DEF;
    end else begin
      s_q <= s_d;
    end
    if (!sys_rst && w_done && !data_clear && s_q.st != PQS_RUN && s_q.wlen != (`PQS_IDX_W+1)'(`PQS_TBL_DEPTH))
      word_mem[s_q.wlen[`PQS_IDX_W-1:0]] <= {s_q.wacc[6:0], data_bit};
    if (!sys_rst && sym_wr && !sym_clear) sym_mem[s_q.slen] <= sym_val;
  end

  // -----------------------------------------------------------------
  // output fifo
  // -----------------------------------------------------------------
  pqs_fifo #(
    .WIDTH (24),
    .DEPTH (`PQS_FIFO_DEPTH),
    .AW    (`PQS_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (s_q.st == PQS_RUN && tick),
    .in_ready  (f_ready),
    .in_data   (sym),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign qam_type_rd = s_q.qtype;
  assign psk_baud_rd = s_q.pbaud;
  assign qam_baud_rd = s_q.qbaud;
  assign psk_carr_rd = s_q.pcarr;
  assign qam_carr_rd = s_q.qcarr;
  assign mark_rd     = s_q.mark;
  assign data_len_rd = s_q.wlen;
  assign busy        = (s_q.st != PQS_IDLE);
  assign sync_out    = s_q.sync;
endmodule : pqs_sequencer

// >>> hw/pqs_cfg.svh
`ifndef PQS_CFG_SVH
`define PQS_CFG_SVH
// -----------------------------------------------------------------
// clock and baud
// -----------------------------------------------------------------
`define PQS_CLK_HZ          32'd10000000
`define PQS_BAUD_MAX_HZ     32'd10000000
`define PQS_BAUD_DEF_HZ     32'd10000
`define PQS_ACC_W           32
// -----------------------------------------------------------------
// tables and marker
// -----------------------------------------------------------------
`define PQS_TBL_DEPTH       4096
`define PQS_IDX_W           12
`define PQS_SYM_TBL_DEPTH   256
`define PQS_PHASE_W         9
`define PQS_PHASE_MAX       9'd359
`define PQS_MARK_MIN        12'h001
`define PQS_MARK_MAX        12'hfa0
`define PQS_MARK_DEF        12'h001
`define PQS_CARR_DEF        1'b1
`define PQS_FIFO_DEPTH      16
`define PQS_FIFO_AW         4
`endif

// >>> hw/pqs_pkg.sv
package pqs_pkg;
  // -----------------------------------------------------------------
  // modes and states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    PQS_BPSK  = 3'h0,
    PQS_NPSK  = 3'h1,
    PQS_UPSK  = 3'h2,
    PQS_QAM16 = 3'h3,
    PQS_QAM64 = 3'h4,
    PQS_QAM256 = 3'h5,
    PQS_UQAM  = 3'h6
  } pqs_mode_t;

  typedef enum logic [2:0] {
    PQS_IDLE = 3'b001,
    PQS_RUN  = 3'b010,
    PQS_STOP = 3'b100
  } pqs_state_t;
endpackage : pqs_pkg

// >>> hw/pqs_fifo.sv
`include "pqs_cfg.svh"
module pqs_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } pqs_fifo_st_t;

  pqs_fifo_st_t      s_q;
  pqs_fifo_st_t      s_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[s_q.rd];

  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = s_q.wr + 1'b1;
    if (pop) s_d.rd = s_q.rd + 1'b1;
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
    if (push) mem[s_q.wr] <= in_data;
  end
endmodule : pqs_fifo

// >>> tb/pqs_monitor.sv
module pqs_monitor (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        qam_type_wr,
  input wire logic        qam_baud_wr,
  input wire logic        qam_carr_val,
  input wire logic        qam_carr_wr,
  input wire logic        mark_wr,
  input wire logic [1:0]  qam_type,
  input wire logic [1:0]  qam_type_rd,
  input wire logic [31:0] qam_baud,
  input wire logic [31:0] qam_baud_rd,
  input wire logic [11:0] mark_val,
  input wire logic [11:0] mark_rd,
  input wire logic        qam_carr_rd,
  input wire logic        busy,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic        sync_out,
  input wire logic [23:0] out_data
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_dflt: assert property ($past(sys_rst) |-> qam_type_rd == 2'h0 && qam_baud_rd == 32'h2710
    && mark_rd == 12'h001 && qam_carr_rd == 1'b1) else $error("wrong value after reset");
  a_type_wr: assert property (qam_type_wr |=> qam_type_rd == $past(qam_type))
    else $error("type not taken");
  a_baud_take: assert property (qam_baud_wr && qam_baud != 32'h0 && qam_baud <= 32'h989680
    |=> qam_baud_rd == $past(qam_baud)) else $error("baud not taken");
  a_baud_refuse: assert property (qam_baud_wr && (qam_baud == 32'h0 || qam_baud > 32'h989680)
    |=> $stable(qam_baud_rd)) else $error("bad baud taken");
  a_mark_take: assert property (mark_wr && mark_val != 12'h0 && mark_val <= 12'hfa0
    |=> mark_rd == $past(mark_val)) else $error("marker not taken");
  a_mark_refuse: assert property (mark_wr && (mark_val == 12'h0 || mark_val > 12'hfa0)
    |=> $stable(mark_rd)) else $error("bad marker taken");
  a_carr_wr: assert property (qam_carr_wr |=> qam_carr_rd == $past(qam_carr_val))
    else $error("carrier enable not taken");
  a_sync_busy: assert property (sync_out |-> busy) else $error("sync while idle");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("symbol lost under stall");
  c_sync: cover property (sync_out);
  c_stall: cover property ((out_valid && !out_ready) [*4]);
  c_refuse: cover property (mark_wr && mark_val == 12'h0);
endmodule : pqs_monitor
bind pqs_sequencer pqs_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .qam_type_wr(qam_type_wr),
  .qam_baud_wr(qam_baud_wr), .qam_carr_val(qam_carr_val), .qam_carr_wr(qam_carr_wr), .mark_wr(mark_wr),
  .qam_type(qam_type), .qam_type_rd(qam_type_rd), .qam_baud(qam_baud), .qam_baud_rd(qam_baud_rd),
  .mark_val(mark_val), .mark_rd(mark_rd), .qam_carr_rd(qam_carr_rd), .busy(busy), .out_valid(out_valid),
  .out_ready(out_ready), .sync_out(sync_out), .out_data(out_data));

// >>> tb/pqs_sink.sv
module pqs_sink (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        stall,
  input wire logic        out_valid,
  input wire logic        sync_out,
  input wire logic [23:0] out_data,
  output logic            out_ready,
  output logic            cycle_end
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] got[$];
  int          sync_cnt = 0;
  logic [1:0]  cyc_q = 2'h0;
  assign out_ready = !stall;
  assign cycle_end = (cyc_q == 2'h3);  // carrier cycle ends every fourth clock
  always @(posedge clock) begin
    cyc_q <= sys_rst ? 2'h0 : cyc_q + 2'h1;
    if (sys_rst) begin
      got.delete();
      sync_cnt <= 0;
    end else begin
      if (out_valid && out_ready) got.push_back(out_data);
      if (sync_out) sync_cnt <= sync_cnt + 1;
    end
  end
endmodule : pqs_sink

// >>> tb/tb_psk_qam_symbol_sequencer.sv
module tb_psk_qam_symbol_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 0, sys_rst = 1, run = 0, stall = 0, dbit = 0, dwr = 0;
  logic [31:0] val = 0, psk_baud_rd, qam_baud_rd;
  logic [7:0]  w = 0;
  logic        psel = 0;
  logic [2:0]  ptype = 0;
  logic [1:0]  qam_type_rd;
  logic [11:0] mark_rd;
  logic [12:0] data_len_rd;
  logic [23:0] out_data;
  logic        psk_carr_rd, qam_carr_rd, busy, out_valid, out_ready, sync_out, cycle_end;
  int          num_errors = 0, compares = 0;
  typedef struct {logic [2:0] k; logic [31:0] v, e;} pqs_row_t;
  pqs_row_t rows[18] = '{'{3'h0, 32'h3, 32'h3}, '{3'h0, 32'h2, 32'h2}, '{3'h0, 32'h1, 32'h1},
    '{3'h0, 32'h0, 32'h0}, '{3'h2, 32'h0, 32'h2710}, '{3'h2, 32'h989680, 32'h989680},
    '{3'h2, 32'h989681, 32'h989680}, '{3'h2, 32'h1, 32'h1}, '{3'h1, 32'h0, 32'h2710},
    '{3'h1, 32'h989680, 32'h989680}, '{3'h3, 32'h0, 32'h1}, '{3'h3, 32'hfa0, 32'hfa0},
    '{3'h3, 32'hfa1, 32'hfa0}, '{3'h3, 32'h1, 32'h1}, '{3'h5, 32'h0, 32'h0}, '{3'h5, 32'h1, 32'h1},
    '{3'h4, 32'h0, 32'h0}, '{3'h4, 32'h1, 32'h1}};
  logic [3:0]  wd[3] = '{4'h4, 4'he, 4'h9};
  pqs_sequencer uut (.clock(clock), .sys_rst(sys_rst), .run(run), .psk_sel(psel), .psk_type(ptype),
    .qam_type(val[1:0]), .qam_type_wr(w[0]), .bpsk_baud(val), .psk_baud(val), .psk_baud_wr(w[1]),
    .qam_baud(val), .qam_baud_wr(w[2]), .psk_carr_val(val[0]), .psk_carr_wr(w[4]), .qam_carr_val(val[0]),
    .qam_carr_wr(w[5]), .mark_val(val[11:0]), .mark_wr(w[3]), .data_clear(w[6]), .data_bit(dbit),
    .data_bit_wr(dwr), .sym_clear(1'b0), .sym_val(val[15:0]), .sym_wr(w[7]), .cycle_end(cycle_end),
    .qam_type_rd(qam_type_rd), .psk_baud_rd(psk_baud_rd), .qam_baud_rd(qam_baud_rd), .psk_carr_rd(psk_carr_rd),
    .qam_carr_rd(qam_carr_rd), .mark_rd(mark_rd), .data_len_rd(data_len_rd), .busy(busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .sync_out(sync_out));
  pqs_sink sink (.clock(clock), .sys_rst(sys_rst), .stall(stall), .out_valid(out_valid), .sync_out(sync_out),
    .out_data(out_data), .out_ready(out_ready), .cycle_end(cycle_end));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] k, input logic [31:0] v);
    @(posedge clock) begin val <= v; w <= 8'h1 << k; end
    @(posedge clock) w <= 8'h0;
    @(posedge clock) #1;
  endtask : wr
  function automatic logic [31:0] rb(input logic [2:0] k);
    case (k)
      3'h0: rb = qam_type_rd;
      3'h1: rb = psk_baud_rd;
      3'h2: rb = qam_baud_rd;
      3'h3: rb = mark_rd;
      3'h4: rb = psk_carr_rd;
      default: rb = qam_carr_rd;
    endcase
  endfunction : rb
  task automatic load(input logic [15:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) @(posedge clock) begin dbit <= bits[i]; dwr <= 1'b1; end
    @(posedge clock) dwr <= 1'b0;
  endtask : load
  task automatic idle;
    for (int k = 0; k < 500 && (busy !== 1'b0 || out_valid !== 1'b0); k++) @(posedge clock) #1;
  endtask : idle
  task automatic go(input int n);
    int base;
    base = sink.got.size();
    @(posedge clock) run <= 1'b1;
    for (int k = 0; k < 500 && sink.got.size() < base + n; k++) @(posedge clock);
    run <= 1'b0;
    idle;
  endtask : go
  function automatic logic [3:0] sym(input logic [23:0] d);
    sym = {d[9:8], d[1:0]};
  endfunction : sym
  task automatic end_sim;
    if (num_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial forever #50 clock = ~clock;
  initial begin
    #(3000 * 100);
    num_errors++;
    end_sim;
  end
  initial begin
    int b;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].k, rows[i].v);
      chk(rb(rows[i].k), rows[i].e);
    end
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock) #1;
    for (int k = 0; k < 6; k++) chk(rb(k[2:0]), (k == 1 || k == 2) ? 32'h2710 : (k == 0 ? 32'h0 : 32'h1));
    wr(3'h2, 32'hf4240);
    wr(3'h3, 32'h3);
    wr(3'h5, 32'h0);
    wr(3'h6, 32'h0);
    load(16'h04e9, 12);
    @(posedge clock) #1 chk(data_len_rd, 32'h3);
    @(posedge clock) run <= 1'b1;
    for (int n = 0; n < 500 && sink.got.size() < 6; n++) @(posedge clock);
    run <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      chk(sym(sink.got[i]), wd[i % 3]);
      chk({sink.got[i][23], sink.got[i][19:17]}, 32'h3);
    end
    idle;
    chk(busy, 32'h0);
    chk(sink.sync_cnt, 32'h2);
    stall <= 1'b1;
    wr(3'h2, 32'h989680);
    @(posedge clock) run <= 1'b1;
    repeat (40) @(posedge clock);
    #1 chk(out_valid, 32'h1);
    @(posedge clock) stall <= 1'b0;
    for (int n = 0; n < 500 && sink.got.size() < 40; n++) @(posedge clock);
    run <= 1'b0;
    for (int i = 7; i < sink.got.size(); i++)
      chk(sym(sink.got[i]), wd[(i - 7) % 3]);
    idle;
    // ----------------------------------------------------------------
    // user phase, user qam, 256-point, two-phase
    // ----------------------------------------------------------------
    @(posedge clock) begin psel <= 1'b1; ptype <= 3'h7; end
    wr(3'h4, 32'h0);
    wr(3'h1, 32'h989680);
    wr(3'h7, 32'h5);
    wr(3'h7, 32'h167);
    wr(3'h6, 32'h0);
    load(16'h0100, 16);
    b = sink.got.size();
    go(2);
    chk({sink.got[b][23], sink.got[b][19:17], sink.got[b][8:0]}, 32'h567);
    chk({sink.got[b+1][23], sink.got[b+1][19:17], sink.got[b+1][8:0]}, 32'h405);
    @(posedge clock) psel <= 1'b0;
    wr(3'h0, 32'h3);
    b = sink.got.size();
    go(2);
    chk(sink.got[b], 32'h000c0167);
    chk(sink.got[b+1], 32'h000c0005);
    wr(3'h0, 32'h2);
    b = sink.got.size();
    go(2);
    chk(sink.got[b], 32'h000a0001);
    chk(sink.got[b+1], 32'h000a0000);
    @(posedge clock) begin psel <= 1'b1; ptype <= 3'h0; end
    wr(3'h1, 32'h1);
    wr(3'h6, 32'h0);
    load(16'h0001, 2);
    wr(3'h2, 32'h989680);
    b = sink.got.size();
    go(2);
    chk(sink.got[b], 32'h00800000);
    chk(sink.got[b+1], 32'h00800100);
    end_sim;
  end
endmodule : tb_psk_qam_symbol_sequencer
